// ### crtrow_pkg.sv
// Register indices, field positions and reset values for the row/cursor/start-address block
package crtrow_pkg;
  localparam logic [7:0] IDX_VERT_OVERFLOW = 8'h07;
  localparam logic [7:0] IDX_SCAN_ROW_CONFIG = 8'h09;
  localparam logic [7:0] IDX_CURSOR_START_LINE = 8'h0a;
  localparam logic [7:0] IDX_CURSOR_END_LINE = 8'h0b;
  localparam logic [7:0] IDX_DISPLAY_BASE_HIGH = 8'h0c;
  localparam logic [7:0] IDX_DISPLAY_BASE_LOW = 8'h0d;
  localparam logic [7:0] IDX_VBLANK_START_LOW = 8'h15;
  localparam logic [7:0] IDX_SPLIT_LINE_LOW = 8'h18;
  localparam logic [7:0] IDX_VBLANK_START_EXT = 8'h33;
  localparam logic [7:0] IDX_DISPLAY_BASE_EXT = 8'h40;
  // scan_row_config fields
  localparam int SRC_DOUBLE_BIT = 7;
  localparam int SRC_SPLIT9_BIT = 6;
  localparam int SRC_VBS9_BIT = 5;
  // vertical_overflow fields
  localparam int OVF_SPLIT8_BIT = 4;
  localparam int OVF_VBS8_BIT = 3;
  // cursor fields
  localparam int CUR_OFF_BIT = 5;
  localparam int CUR_SKEW_LSB = 5;
  // display_base_high update request bit
  localparam int BASE_REQ_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CURSOR_START_RESET = 8'h20;
  localparam logic [7:0] SPLIT_LOW_RESET = 8'hff;
  localparam logic [7:0] OVF_RESET = 8'h10;
  localparam logic [7:0] SRC_RESET = 8'h40;
  localparam int MAX_SKEW = 3;
endpackage : crtrow_pkg

// ### crtrow_core.sv
// Vertical row scan, split line, blanking start, text cursor and start address logic
//
// Behaviour
// - Double-scan bit halves the row scan counter clock; each line shows twice.
// - Split line is 10 bits: config bit 6, overflow bit 4, split_line_low.
// - At split line the address counter restarts at zero for remaining lines.
// - io_control bit 0 picks standard or extended field widths.
// - Standard blanking start: config bit 5, overflow bit 3, vblank_start_low.
// - Extended blanking start: vblank_start_ext bits 3-0 over vblank_start_low.
// - Vertical blanking begins on the line equal to blanking start, counted from 0.
// - Config bits 4-0 are row height minus one; row counter wraps after it.
// - Cursor only shown in text modes; graphics ignores all cursor settings.
// - Cursor-off bit 5 set suppresses the cursor, clear shows it.
// - Cursor starts on box line from cursor_start_line bits 4-0, top is 0.
// - Cursor stops after box line from cursor_end_line bits 4-0.
// - Cursor skew bits 6-5 delay cursor by 0 to 3 character clocks.
// - Display fetch begins at the start address offset into the frame buffer.
// - Standard start address is 16 bits: high and low registers.
// - Extended start address is 20 bits: ext bits 3-0, high, low.
// - Extended address double-buffered; load at next vsync after bit 7 set.
// - After the synchronized load hardware clears the request bit itself.
`timescale 1ns/1ns
`default_nettype none
module crtrow_core
  import crtrow_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Indexed register port
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_idx_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Mode inputs
  input wire logic io_ext_mode_in,
  input wire logic text_mode_in,
  input wire logic [4:0] preset_row_in,
  input wire logic [11:0] row_pitch_in,
  // Display timing
  input wire logic char_clk_en_in,
  input wire logic hline_start_in,
  input wire logic frame_start_in,
  input wire logic vsync_in,
  input wire logic cursor_loc_hit_in,
  // Outputs to fetch and video
  output logic [11:0] scan_line_out,
  output logic [4:0] row_scan_out,
  output logic vblank_out,
  output logic split_hit_out,
  output logic [19:0] start_addr_out,
  output logic [19:0] row_addr_out,
  output logic cursor_out
);
  import crtrow_pkg::*;

  logic [7:0] vert_overflow_r;
  logic [7:0] scan_row_config_r;
  logic [7:0] cursor_start_line_r;
  logic [7:0] cursor_end_line_r;
  logic [7:0] display_base_high_r;
  logic [7:0] display_base_low_r;
  logic [7:0] vblank_start_low_r;
  logic [7:0] split_line_low_r;
  logic [7:0] vblank_start_ext_r;
  logic [7:0] display_base_ext_r;
  logic [19:0] active_base_r;
  logic vsync_d_r;
  logic load_now;
  logic [11:0] scan_line_r;
  logic [4:0] row_scan_r;
  logic ds_phase_r;
  logic vblank_r;
  logic split_r;
  logic [19:0] row_addr_r;
  logic [MAX_SKEW:0] cur_pipe_r;
  logic cursor_r;
  logic [9:0] split_line;
  logic [11:0] vblank_start;
  logic [19:0] prog_base;
  logic row_step;
  logic row_wrap;
  logic cursor_raw;

  // Register writes
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      vert_overflow_r <= OVF_RESET;
      scan_row_config_r <= SRC_RESET;
      cursor_start_line_r <= CURSOR_START_RESET;
      cursor_end_line_r <= REG_RESET;
      display_base_low_r <= REG_RESET;
      vblank_start_low_r <= REG_RESET;
      split_line_low_r <= SPLIT_LOW_RESET;
      vblank_start_ext_r <= REG_RESET;
      display_base_ext_r <= REG_RESET;
    end
    else if (reg_wr_in)
    begin
      case (reg_idx_in)
        IDX_VERT_OVERFLOW: vert_overflow_r <= reg_wdata_in;
        IDX_SCAN_ROW_CONFIG: scan_row_config_r <= reg_wdata_in;
        IDX_CURSOR_START_LINE: cursor_start_line_r <= reg_wdata_in;
        IDX_CURSOR_END_LINE: cursor_end_line_r <= reg_wdata_in;
        IDX_DISPLAY_BASE_LOW: display_base_low_r <= reg_wdata_in;
        IDX_VBLANK_START_LOW: vblank_start_low_r <= reg_wdata_in;
        IDX_SPLIT_LINE_LOW: split_line_low_r <= reg_wdata_in;
        IDX_VBLANK_START_EXT: vblank_start_ext_r <= reg_wdata_in;
        IDX_DISPLAY_BASE_EXT: display_base_ext_r <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // High byte kept apart: hardware clears its request bit after the load
  assign load_now = vsync_in && !vsync_d_r && io_ext_mode_in && display_base_high_r[BASE_REQ_BIT];

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      display_base_high_r <= REG_RESET;
    else if (reg_wr_in && reg_idx_in == IDX_DISPLAY_BASE_HIGH)
      display_base_high_r <= reg_wdata_in;
    else if (load_now)
      display_base_high_r[BASE_REQ_BIT] <= 1'b0;
  end

  // Read back
  always_comb
  begin
    case (reg_idx_in)
      IDX_VERT_OVERFLOW: reg_rdata_out = vert_overflow_r;
      IDX_SCAN_ROW_CONFIG: reg_rdata_out = scan_row_config_r;
      IDX_CURSOR_START_LINE: reg_rdata_out = {2'b00, cursor_start_line_r[5:0]};
      IDX_CURSOR_END_LINE: reg_rdata_out = {1'b0, cursor_end_line_r[6:0]};
      IDX_DISPLAY_BASE_HIGH: reg_rdata_out = display_base_high_r;
      IDX_DISPLAY_BASE_LOW: reg_rdata_out = display_base_low_r;
      IDX_VBLANK_START_LOW: reg_rdata_out = vblank_start_low_r;
      IDX_SPLIT_LINE_LOW: reg_rdata_out = split_line_low_r;
      IDX_VBLANK_START_EXT: reg_rdata_out = vblank_start_ext_r;
      IDX_DISPLAY_BASE_EXT: reg_rdata_out = display_base_ext_r;
      default: reg_rdata_out = 8'h00;
    endcase
  end

  // Derived fields
  assign split_line = {scan_row_config_r[SRC_SPLIT9_BIT], vert_overflow_r[OVF_SPLIT8_BIT], split_line_low_r};
  always_comb
  begin
    if (io_ext_mode_in)
    begin
      vblank_start = {vblank_start_ext_r[3:0], vblank_start_low_r};
      prog_base = {display_base_ext_r[3:0], display_base_high_r, display_base_low_r};
    end
    else
    begin
      vblank_start = {2'b00, scan_row_config_r[SRC_VBS9_BIT], vert_overflow_r[OVF_VBS8_BIT],
                      vblank_start_low_r};
      prog_base = {4'h0, display_base_high_r, display_base_low_r};
    end
  end

  // Active start address; standard mode follows registers directly
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      active_base_r <= 20'h00000;
      vsync_d_r <= 1'b0;
    end
    else
    begin
      vsync_d_r <= vsync_in;
      if (!io_ext_mode_in)
        active_base_r <= prog_base;
      else if (load_now)
        active_base_r <= prog_base;
    end
  end

  // Scan line counter, zero on first active line
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      scan_line_r <= 12'h000;
    else if (frame_start_in)
      scan_line_r <= 12'h000;
    else if (hline_start_in)
      scan_line_r <= scan_line_r + 12'h001;
  end

  // Double scan gates every other line
  assign row_step = hline_start_in && (!scan_row_config_r[SRC_DOUBLE_BIT] || ds_phase_r);
  assign row_wrap = row_scan_r == scan_row_config_r[4:0];

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ds_phase_r <= 1'b0;
      row_scan_r <= 5'h00;
    end
    else if (frame_start_in)
    begin
      ds_phase_r <= 1'b0;
      row_scan_r <= preset_row_in;
    end
    else if (hline_start_in)
    begin
      ds_phase_r <= !ds_phase_r;
      if (row_step)
        row_scan_r <= row_wrap ? 5'h00 : row_scan_r + 5'h01;
    end
  end

  // Blanking starts on the matching line and holds until next frame
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      vblank_r <= 1'b0;
    else if (frame_start_in)
      vblank_r <= 1'b0;
    else if (scan_line_r == vblank_start)
      vblank_r <= 1'b1;
  end

  // Row address: base at frame start, zero at split line, pitch per text row
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      row_addr_r <= 20'h00000;
      split_r <= 1'b0;
    end
    else if (frame_start_in)
    begin
      row_addr_r <= active_base_r;
      split_r <= 1'b0;
    end
    else if (hline_start_in && !split_r && scan_line_r + 12'h001 == {2'b00, split_line})
    begin
      row_addr_r <= 20'h00000;
      split_r <= 1'b1;
    end
    else if (row_step && row_wrap)
      row_addr_r <= row_addr_r + {8'h00, row_pitch_in};
  end

  // Cursor: text mode only, line window, skew by character clocks
  assign cursor_raw = text_mode_in && !cursor_start_line_r[CUR_OFF_BIT] && cursor_loc_hit_in
    && row_scan_r >= cursor_start_line_r[4:0]
    && row_scan_r <= cursor_end_line_r[4:0];

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cur_pipe_r <= '0;
      cursor_r <= 1'b0;
    end
    else
    begin
      if (char_clk_en_in)
        cur_pipe_r <= {cur_pipe_r[MAX_SKEW-1:0], cursor_raw};
      // Tap 0 is the unskewed sample, taken on the last character clock before this edge
      cursor_r <= text_mode_in && cur_pipe_r[cursor_end_line_r[CUR_SKEW_LSB+:2]];
    end
  end

  assign scan_line_out = scan_line_r;
  assign row_scan_out = row_scan_r;
  assign vblank_out = vblank_r;
  assign split_hit_out = split_r;
  assign start_addr_out = active_base_r;
  assign row_addr_out = row_addr_r;
  assign cursor_out = cursor_r;
endmodule // crtrow_core
`default_nettype wire

// ### crtrow_asserts.sv
// Port-level checks for the row/cursor/start-address core
`timescale 1ns/1ns
`default_nettype none
module crtrow_asserts (
  // Clock, reset and modes
  input wire logic sys_clk_in, sys_rst_in, io_ext_mode_in, text_mode_in,
  // Timing inputs
  input wire logic hline_start_in, frame_start_in, vsync_in,
  input wire logic [4:0] preset_row_in,
  // Watched outputs
  input wire logic [11:0] scan_line_out,
  input wire logic [4:0] row_scan_out,
  input wire logic vblank_out, split_hit_out, cursor_out,
  input wire logic [19:0] start_addr_out, row_addr_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_line;
    hline_start_in && !frame_start_in;
  endsequence
  // Ext mode held two cycles and no vsync rise seen: no load may land
  sequence s_noload;
    $past(io_ext_mode_in) && $past(io_ext_mode_in, 2) && !($past(vsync_in) && !$past(vsync_in, 2));
  endsequence
  sequence s_gfx;
    !text_mode_in [*8] ##1 !text_mode_in [*4];
  endsequence
  a_scan_step: assert property (s_line |=> scan_line_out == $past(scan_line_out) + 12'h001)
    else $error("scan line did not step on line start");
  a_frame_clear: assert property (frame_start_in |=> scan_line_out == 12'h000 &&
    row_scan_out == $past(preset_row_in) && !vblank_out && !split_hit_out)
    else $error("frame start did not restart counters");
  a_frame_addr: assert property (frame_start_in |=> row_addr_out == $past(start_addr_out))
    else $error("frame did not fetch from start address");
  a_split_addr: assert property ($rose(split_hit_out) |-> row_addr_out == 20'h00000)
    else $error("split line did not restart address at zero");
  a_split_hold: assert property (split_hit_out && !frame_start_in |=> split_hit_out)
    else $error("split state dropped inside frame");
  a_vblank_hold: assert property (vblank_out && !frame_start_in |=> vblank_out)
    else $error("blanking dropped inside frame");
  a_addr_hold: assert property (s_noload |-> $stable(start_addr_out))
    else $error("extended start address changed without vsync");
  a_cursor_gfx: assert property (s_gfx |-> !cursor_out)
    else $error("cursor shown in graphics mode");
endmodule // crtrow_asserts
bind crtrow_core crtrow_asserts u_chk (.sys_clk_in, .sys_rst_in, .io_ext_mode_in, .text_mode_in,
  .hline_start_in, .frame_start_in, .vsync_in, .preset_row_in, .scan_line_out, .row_scan_out,
  .vblank_out, .split_hit_out, .cursor_out, .start_addr_out, .row_addr_out);
`default_nettype wire

// ### crtrow_timing.sv
// Display timing source: character clock, line and frame pulses
`timescale 1ns/1ns
`default_nettype none
module crtrow_timing (
  input wire logic clk_in, rst_in, go_in,
  output logic cen_out, hl_out, fs_out
);
  logic [3:0] cnt_r;
  // Line pulse is masked while go_in is high, so line and frame never coincide; the counter restarts on a frame
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      {cnt_r, cen_out, hl_out, fs_out} <= '0;
    else
    begin
      cnt_r <= go_in ? 4'h1 : cnt_r + 4'h1;
      cen_out <= cnt_r[0];
      hl_out <= !go_in && cnt_r == 4'hf;
      fs_out <= go_in;
    end
endmodule // crtrow_timing
`default_nettype wire

// ### crtrow_tb.sv
// Self-checking bench for the row/cursor/start-address core
`timescale 1ns/1ns
`default_nettype none
module tb;
  import crtrow_pkg::*;
  logic clk = 0, rst = 1, wr = 0, ext = 0, text = 1, vs = 0, go = 0;
  logic [7:0] idx = 8'h00, wd = 8'h00, rd;
  logic cen, hl, fs, vb, sh, cur;
  logic [11:0] sl;
  logic [4:0] rs;
  logic [19:0] sa, ra;
  int miscompares = 0, n_checks = 0;
  crtrow_core u_dut (.sys_clk_in(clk), .sys_rst_in(rst), .reg_wr_in(wr), .reg_idx_in(idx),
    .reg_wdata_in(wd), .reg_rdata_out(rd), .io_ext_mode_in(ext), .text_mode_in(text),
    .preset_row_in(5'h00), .row_pitch_in(12'h050), .char_clk_en_in(cen), .hline_start_in(hl),
    .frame_start_in(fs), .vsync_in(vs), .cursor_loc_hit_in(1'b1), .scan_line_out(sl),
    .row_scan_out(rs), .vblank_out(vb), .split_hit_out(sh), .start_addr_out(sa),
    .row_addr_out(ra), .cursor_out(cur));
  crtrow_timing u_tim (.clk_in(clk), .rst_in(rst), .go_in(go), .cen_out(cen), .hl_out(hl), .fs_out(fs));
  initial forever #4 clk = ~clk;
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [19:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] i, d);
    @(posedge clk);
    idx <= i;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] i, exp);
    @(posedge clk);
    idx <= i;
    #1 chk(rd, exp);
  endtask
  // Pulses are watched on the falling edge to stay clear of the launch edge
  task automatic lines(input int n);
    repeat (n)
      do @(negedge clk); while (hl !== 1'b1);
    @(posedge clk);
    #1;
  endtask
  task automatic frame;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    lines(0);
  endtask
  task automatic vbrun(input int n);
    frame();
    lines(n);
    chk(sl, 20'(n));
    chk(vb, 0);
    @(posedge clk);
    #1 chk(vb, 1);
  endtask
  task automatic curchk(input logic [7:0] s, input logic t, e);
    wreg(IDX_CURSOR_START_LINE, s);
    text <= t;
    repeat (12) @(posedge clk);
    #1 chk(cur, e);
  endtask
  initial
  begin
    #400000;
    miscompares++;
    report_and_stop();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rreg(IDX_CURSOR_START_LINE, CURSOR_START_RESET);
    rreg(IDX_SCAN_ROW_CONFIG, SRC_RESET);
    rreg(IDX_VERT_OVERFLOW, OVF_RESET);
    wreg(8'h55, 8'hff);
    rreg(8'h55, 8'h00);
    // Double scan, four-line rows, split at line 3
    wreg(IDX_SCAN_ROW_CONFIG, 8'h83);
    wreg(IDX_VERT_OVERFLOW, 8'h08);
    wreg(IDX_SPLIT_LINE_LOW, 8'h03);
    wreg(IDX_DISPLAY_BASE_HIGH, 8'h12);
    wreg(IDX_DISPLAY_BASE_LOW, 8'h34);
    frame();
    chk(sa, 20'h01234);
    lines(2);
    chk(rs, 1);
    chk(ra, 20'h01234);
    chk(sh, 0);
    lines(1);
    chk(sh, 1);
    chk(ra, 0);
    // Extended address waits for vsync after the request bit
    ext <= 1'b1;
    wreg(IDX_DISPLAY_BASE_EXT, 8'h05);
    wreg(IDX_DISPLAY_BASE_LOW, 8'hbc);
    wreg(IDX_DISPLAY_BASE_HIGH, 8'h9a);
    chk(sa, 20'h01234);
    vs <= 1'b1;
    repeat (2) @(posedge clk);
    vs <= 1'b0;
    #1 chk(sa, 20'h59abc);
    rreg(IDX_DISPLAY_BASE_HIGH, 8'h1a);
    wreg(IDX_SCAN_ROW_CONFIG, 8'h23);
    wreg(IDX_VBLANK_START_LOW, 8'h05);
    vbrun(5);
    chk(rs, 1);
    chk(ra, 20'h00050);
    ext <= 1'b0;
    vbrun(773);
    // Full-height window so the cursor check does not hang on the current row
    wreg(IDX_CURSOR_END_LINE, 8'h1f);
    curchk(8'h00, 1'b1, 1'b1);
    curchk(8'h05, 1'b1, 1'b0);
    curchk(8'h20, 1'b1, 1'b0);
    curchk(8'h00, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
